// *** psr_pkg.sv ***
package psr_pkg;
    localparam int REG_AW = 4;
    localparam int REG_DW = 16;
    // Register indices
    localparam logic [3:0] IDX_STATUS = 4'h1;
    localparam logic [3:0] IDX_IDENT_HI = 4'h2;
    localparam logic [3:0] IDX_IDENT_LO = 4'h3;
    localparam logic [3:0] IDX_CTRL = 4'h8;
    localparam logic [3:0] IDX_IRQ_STAT = 4'h9;
    localparam logic [3:0] IDX_IRQ_MASK = 4'ha;
    localparam logic [3:0] IDX_AN_STATE = 4'hb;
    // Fixed capability bits of the status word
    localparam logic [15:0] STATUS_FIXED = 16'h7809;
    // Status field positions
    localparam int BIT_AN_DONE = 5;
    localparam int BIT_RFAULT = 4;
    localparam int BIT_LINK = 2;
    localparam int BIT_JABBER = 1;
    // Ident field positions
    localparam int ID_OUI_LSB = 10;
    localparam int ID_MODEL_LSB = 4;
    // Ident reset values; arbitrary neutral values
    localparam logic [15:0] RST_IDENT_HI = 16'h1234;
    localparam logic [5:0] RST_OUI_LOW = 6'h15;
    localparam logic [5:0] RST_MODEL = 6'h2a;
    localparam logic [3:0] RST_REV = 4'h5;
    // Control register: bit 0 power down, bit 1 autoneg enable
    localparam int CTRL_PWR_DWN = 0;
    localparam int CTRL_AN_EN = 1;
    localparam logic [1:0] RST_CTRL = 2'h3;
    // Interrupt bits
    localparam int IRQ_AN_DONE = 0;
    localparam int IRQ_RFAULT = 1;
    localparam int IRQ_LINK_DOWN = 2;
    localparam int IRQ_JABBER = 3;
    localparam int IRQ_W = 4;
    // Autoneg time: two seconds, counted in ms at 25 MHz
    localparam int AN_TIME_MS = 2000;
    localparam int CLK_HZ = 25000000;
    localparam int AN_CYCLES = AN_TIME_MS * (CLK_HZ / 1000);
    typedef enum logic [1:0] {
        PSR_AN_OFF = 2'b00,
        PSR_AN_RUN = 2'b01,
        PSR_AN_DONE = 2'b11
    } psr_an_e;
    // Raw live conditions from the signal path
    typedef struct packed {
        logic link_up;
        logic remote_fault;
        logic jabber;
    } psr_cond_s;
endpackage : psr_pkg

// *** psr_sync.sv ***
`timescale 1ns/1ns
// Two-flop synchroniser for pin-level inputs
module psr_sync #(
    parameter int W = 3
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    // First stage is read only by the second
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : psr_sync

// *** psr_an_timer.sv ***
`timescale 1ns/1ns
// Autoneg completion timer, restarts whenever enable or power drops
module psr_an_timer
    import psr_pkg::*;
#(
    parameter int CYCLES = AN_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic run,
    output logic done,
    output psr_an_e state
);
    logic [31:0] cnt;
    psr_an_e next_state;
    wire logic expired = (cnt >= 32'(CYCLES - 1));
    // Next state
    always_comb begin
        next_state = state;
        case (state)
            PSR_AN_OFF: if (run) next_state = PSR_AN_RUN;
            PSR_AN_RUN: begin
                if (!run) next_state = PSR_AN_OFF;
                else if (expired) next_state = PSR_AN_DONE;
            end
            PSR_AN_DONE: if (!run) next_state = PSR_AN_OFF;
            default: next_state = PSR_AN_OFF;
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= PSR_AN_OFF;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= (state == PSR_AN_RUN) ? cnt + 32'h1 : '0;
        end
    end
    assign done = (state == PSR_AN_DONE);
    // no completion before the full time
    an_time_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(done) |-> $past(state) == PSR_AN_RUN && $past(cnt) == 32'(CYCLES - 1))
        else $error("autoneg completed early");
endmodule : psr_an_timer

// *** psr_top.sv ***
// Added by the designer: strobed register access.
`timescale 1ns/1ns
// PHY status and identity register bank
module psr_top
    import psr_pkg::*;
#(
    parameter int AN_CYC = AN_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [REG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [REG_DW-1:0] reg_rdata,
    input wire psr_cond_s cond_pin,
    output logic irq
);
    psr_cond_s cond;
    logic [1:0] ctrl;
    logic [15:0] ident_hi;
    logic [15:0] ident_lo;
    logic rfault_lat;
    logic jabber_lat;
    logic link_lat;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic an_done;
    logic an_done_d;
    logic link_d;
    psr_an_e an_state;

    // Live conditions come from the analog side, so synchronise
    psr_sync #(.W(3)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .d(cond_pin),
        .q(cond)
    );

    // Autoneg runs only when enabled and out of power down
    wire logic an_run = ctrl[CTRL_AN_EN] && !ctrl[CTRL_PWR_DWN];
    psr_an_timer #(.CYCLES(AN_CYC)) u_an (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .run(an_run),
        .done(an_done),
        .state(an_state)
    );

    // Address decode
    // register indices
    wire logic hit_status = (reg_addr == IDX_STATUS);
    wire logic hit_id_hi = (reg_addr == IDX_IDENT_HI);
    wire logic hit_id_lo = (reg_addr == IDX_IDENT_LO);
    wire logic hit_ctrl = (reg_addr == IDX_CTRL);
    wire logic hit_istat = (reg_addr == IDX_IRQ_STAT);
    wire logic hit_imask = (reg_addr == IDX_IRQ_MASK);
    wire logic hit_anst = (reg_addr == IDX_AN_STATE);
    wire logic status_read = reg_rd && hit_status;

    // Status word assembly
    // constant bits; reserved reads zero
    wire logic [15:0] status_word = STATUS_FIXED
        | (16'(an_done) << BIT_AN_DONE)
        | (16'(rfault_lat) << BIT_RFAULT)
        | (16'(link_lat) << BIT_LINK)
        | (16'(jabber_lat) << BIT_JABBER);

    // Read mux; unmapped indices read zero
    wire logic [15:0] next_rdata =
        hit_status ? status_word :
        hit_id_hi ? ident_hi :
        hit_id_lo ? ident_lo :
        hit_ctrl ? {14'h0, ctrl} :
        hit_istat ? {12'h0, irq_stat} :
        hit_imask ? {12'h0, irq_mask} :
        hit_anst ? {14'h0, an_state} : 16'h0;

    // Interrupt events: sets win over write-one clears
    wire logic [IRQ_W-1:0] irq_evt = {
        cond.jabber & ~jabber_lat,
        link_d & ~cond.link_up,
        cond.remote_fault & ~rfault_lat,
        an_done & ~an_done_d
    };
    wire logic [IRQ_W-1:0] irq_clr = (reg_wr && hit_istat) ? reg_wdata[IRQ_W-1:0] : '0;

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (!rst_n) reg_rdata <= '0;
        else reg_rdata <= reg_rd ? next_rdata : 16'h0;
    end

    // Latching indicators: a read releases them to live value
    // fault and jabber latch high until read, link latches low
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rfault_lat <= 1'b0;
            jabber_lat <= 1'b0;
            link_lat <= 1'b0;
        end else if (status_read) begin
            rfault_lat <= cond.remote_fault;
            jabber_lat <= cond.jabber;
            link_lat <= cond.link_up;
        end else begin
            rfault_lat <= rfault_lat | cond.remote_fault;
            jabber_lat <= jabber_lat | cond.jabber;
            link_lat <= link_lat & cond.link_up;
        end
    end

    // Previous live link level, for the link-down interrupt event
    // link delayed one cycle, no read needed
    always_ff @(posedge sys_clk) begin
        if (!rst_n) link_d <= 1'b0;
        else link_d <= cond.link_up;
    end

    // Ident registers are writable so firmware may override
    // ident fields
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ident_hi <= RST_IDENT_HI;
            ident_lo <= {RST_OUI_LOW, RST_MODEL, RST_REV};
        end else begin
            if (reg_wr && hit_id_hi) ident_hi <= reg_wdata;
            if (reg_wr && hit_id_lo) ident_lo <= reg_wdata;
        end
    end

    // Control and interrupt registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl <= RST_CTRL;
            irq_mask <= '0;
            irq_stat <= '0;
            an_done_d <= 1'b0;
        end else begin
            if (reg_wr && hit_ctrl) ctrl <= reg_wdata[1:0];
            if (reg_wr && hit_imask) irq_mask <= reg_wdata[IRQ_W-1:0];
            irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
            an_done_d <= an_done;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // Status word as read back, one cycle after the strobe
    // Fixed bits are checked on the data, so a wrong mux index shows up too
    // capability bits as read
    caps_fixed_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(status_read) |-> reg_rdata[15:9] == 7'h3c && reg_rdata[3] && reg_rdata[0])
        else $error("capability bits wrong");
    modes_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        status_read |=> !reg_rdata[15] && !reg_rdata[10] && !reg_rdata[9])
        else $error("unsupported mode read as able");
    resv_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        status_read |=> reg_rdata[8:6] == 3'h0)
        else $error("reserved status bits set");
    an_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        status_read |=> reg_rdata[BIT_AN_DONE] == $past(an_done))
        else $error("autoneg bit mismatch");
    an_able_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        status_read |=> reg_rdata[3])
        else $error("autoneg ability bit clear");
    ext_cap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        status_read |=> reg_rdata[0])
        else $error("extended capability bit clear");
    four_caps_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        status_read |=> reg_rdata[14:11] == 4'hf)
        else $error("supported mode read as unable");
    rfault_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        status_read |=> reg_rdata[BIT_RFAULT] == $past(rfault_lat))
        else $error("remote fault bit mismatch");
    link_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        status_read |=> reg_rdata[BIT_LINK] == $past(link_lat))
        else $error("link bit mismatch");
    jabber_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        status_read |=> reg_rdata[BIT_JABBER] == $past(jabber_lat))
        else $error("jabber bit mismatch");

    // Latching indicators
    // The read edge reloads live values, so an event in that cycle is kept
    // remote fault held
    rfault_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rfault_lat && !status_read |=> rfault_lat)
        else $error("remote fault lost before read");
    rfault_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cond.remote_fault |=> rfault_lat)
        else $error("remote fault not latched");
    jabber_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cond.jabber |=> jabber_lat)
        else $error("jabber not latched");
    jabber_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        jabber_lat && !status_read |=> jabber_lat)
        else $error("jabber lost before read");
    link_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !link_lat && !status_read |=> !link_lat)
        else $error("link rose without a read");
    link_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !cond.link_up |=> !link_lat)
        else $error("link drop not latched");
    rfault_rd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        status_read |=> rfault_lat == $past(cond.remote_fault))
        else $error("remote fault not reloaded by read");
    jabber_rd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        status_read |=> jabber_lat == $past(cond.jabber))
        else $error("jabber not reloaded by read");
    link_rd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        status_read |=> link_lat == $past(cond.link_up))
        else $error("link not reloaded by read");

    // Identity registers
    // ident write takes
    ident_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr && hit_id_hi |=> ident_hi == $past(reg_wdata))
        else $error("ident high write lost");
    ident_hi_rd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_rd && reg_addr == 4'h2 |=> reg_rdata == $past(ident_hi))
        else $error("ident high read wrong");
    ident_hi_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(reg_wr && hit_id_hi) |=> $stable(ident_hi))
        else $error("ident high changed without a write");
    ident_rd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_rd && hit_id_lo |=> reg_rdata == $past(ident_lo))
        else $error("ident low read wrong");
    ident_lo_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr && hit_id_lo |=> ident_lo == $past(reg_wdata))
        else $error("ident low write lost");
    ident_lo_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(reg_wr && hit_id_lo) |=> $stable(ident_lo))
        else $error("ident low changed without a write");
    oui_field_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_rd && hit_id_lo |=> reg_rdata[15:ID_OUI_LSB] == $past(ident_lo[15:ID_OUI_LSB]))
        else $error("OUI field read wrong");
    model_field_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_rd && hit_id_lo |=> reg_rdata[ID_OUI_LSB-1:ID_MODEL_LSB] == $past(ident_lo[ID_OUI_LSB-1:ID_MODEL_LSB]))
        else $error("model field read wrong");
    rev_field_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_rd && hit_id_lo |=> reg_rdata[ID_MODEL_LSB-1:0] == $past(ident_lo[ID_MODEL_LSB-1:0]))
        else $error("revision field read wrong");

    // Read-only words and autoneg
    // status write ignored
    status_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr && hit_status |=> $stable(ident_hi) && $stable(ident_lo) && $stable(ctrl))
        else $error("status write changed a register");
    an_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !an_run |=> !an_done)
        else $error("autoneg done while stopped");
    an_stay_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        an_done && an_run |=> an_done)
        else $error("autoneg done dropped while running");
    an_state_rd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_rd && hit_anst |=> reg_rdata[15:2] == 14'h0)
        else $error("autoneg state read wrong");
    an_run_state_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        an_run |=> an_state != PSR_AN_OFF)
        else $error("autoneg did not start");
    an_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        an_state == PSR_AN_OFF |=> !an_done)
        else $error("autoneg done without running");

    // Read port and interrupt bookkeeping
    // Set wins over a write-one clear so no event slips between polls
    // Read data for one cycle only
    rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == 16'h0)
        else $error("read data outside its cycle");
    // Unmapped indices 4 to 7 read zero
    unmapped_rd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_rd && reg_addr[3:2] == 2'h1 |=> reg_rdata == 16'h0)
        else $error("unmapped index read nonzero");
    // Control write takes
    ctrl_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr && hit_ctrl |=> ctrl == $past(reg_wdata[1:0]))
        else $error("control write lost");
    // Mask write takes
    mask_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr && hit_imask |=> irq_mask == $past(reg_wdata[IRQ_W-1:0]))
        else $error("mask write lost");
    // Status bits sticky without a clear
    irq_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(reg_wr && hit_istat) |=> (irq_stat & $past(irq_stat)) == $past(irq_stat))
        else $error("interrupt status lost without a clear");
    // Write one clears when nothing new
    irq_w1c_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr && hit_istat && irq_evt == 4'h0 |=> (irq_stat & $past(reg_wdata[IRQ_W-1:0])) == 4'h0)
        else $error("interrupt status not cleared");
    // Events win over a clear in the same cycle
    irq_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        irq_evt != 4'h0 |=> (irq_stat & $past(irq_evt)) == $past(irq_evt))
        else $error("interrupt event lost");
    an_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(an_done) |=> irq_stat[IRQ_AN_DONE])
        else $error("autoneg interrupt missing");
    link_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(cond.link_up) |=> irq_stat[IRQ_LINK_DOWN])
        else $error("link interrupt missing");
    rfault_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cond.remote_fault && !rfault_lat |=> irq_stat[IRQ_RFAULT])
        else $error("remote fault interrupt missing");
    jabber_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cond.jabber && !jabber_lat |=> irq_stat[IRQ_JABBER])
        else $error("jabber interrupt missing");
    // Masked events keep the line low
    irq_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        irq_mask == 4'h0 |-> !irq)
        else $error("interrupt raised while masked");
    // Unmasked event drives the line
    irq_line_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (irq_stat & irq_mask) != 4'h0 |-> irq)
        else $error("interrupt line low with a pending event");
endmodule : psr_top

// *** psr_top_tb_top.sv ***
`timescale 1ns/1ns
// Bench for the status and identity register bank, driven through the register port
module psr_top_tb_top;
    import psr_pkg::*;
    // Short autoneg so the run stays brief; expectations follow this value
    localparam int AN_SIM = 20;
    logic sys_clk;
    logic rst_n;
    logic [REG_AW-1:0] reg_addr;
    logic [REG_DW-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [REG_DW-1:0] reg_rdata;
    psr_cond_s cond_pin;
    logic irq;
    int n_fail;
    int n_checks;

    psr_top #(.AN_CYC(AN_SIM)) i_psr_top (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .cond_pin(cond_pin),
        .irq(irq)
    );

    // 25 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Ends the run with the verdict
    task automatic complete_run();
        if (n_fail == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    // Case equality so an unknown never matches
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One-cycle write strobe; takes effect at the edge that samples it
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample just after that edge
    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(what, reg_rdata, exp);
    endtask : rd

    // Pin levels pass a two-flop synchroniser, so allow a few cycles
    task automatic pins(input logic [2:0] v, input int n);
        @(posedge sys_clk);
        cond_pin <= psr_cond_s'(v);
        repeat (n) @(posedge sys_clk);
    endtask : pins

    // Watchdog: the sequence needs about 120 cycles
    initial begin
        #(40 * 3000);
        n_fail++;
        complete_run();
    end

    initial begin
        n_fail = 0;
        n_checks = 0;
        rst_n = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cond_pin = psr_cond_s'(3'h0);
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        check("irq", {15'h0000, irq}, 16'h0000);
        rd(4'h1, 16'h7809, "status");
        rd(4'h2, 16'h1234, "ident_hi");
        rd(4'h3, 16'h56a5, "ident_lo");
        rd(4'h5, 16'h0000, "unmapped");
        wr(4'h1, 16'hffff);
        rd(4'h1, 16'h7809, "status_wr");
        wr(4'h1, 16'h0000);
        rd(4'h1, 16'h7809, "status_wr0");
        wr(4'h2, 16'hedcb);
        wr(4'h3, 16'ha95a);
        rd(4'h2, 16'hedcb, "ident_hi_rw");
        rd(4'h3, 16'ha95a, "ident_lo_rw");
        wr(4'ha, 16'h0000);
        pins(3'h3, 4);
        pins(3'h0, 4);
        rd(4'h1, 16'h781b, "status_lh");
        rd(4'h1, 16'h7809, "status_lh2");
        pins(3'h4, 4);
        rd(4'h1, 16'h7809, "link_first");
        rd(4'h1, 16'h780d, "link_up");
        pins(3'h0, 3);
        pins(3'h4, 4);
        rd(4'h1, 16'h7809, "link_drop");
        rd(4'h1, 16'h780d, "link_back");
        rd(4'h9, 16'h000e, "irq_stat");
        check("irq_masked", {15'h0000, irq}, 16'h0000);
        wr(4'h8, 16'h0002);
        rd(4'h1, 16'h780d, "an_busy");
        rd(4'hb, 16'h0001, "an_run");
        repeat (AN_SIM + 5) @(posedge sys_clk);
        rd(4'h1, 16'h782d, "an_done");
        rd(4'hb, 16'h0003, "an_state");
        rd(4'h9, 16'h000f, "irq_stat_an");
        // Interrupt mask and write-one-to-clear
        wr(4'ha, 16'h0001);
        check("irq_on", {15'h0000, irq}, 16'h0001);
        wr(4'h9, 16'h0001);
        check("irq_clr", {15'h0000, irq}, 16'h0000);
        wr(4'ha, 16'h000f);
        check("irq_rest", {15'h0000, irq}, 16'h0001);
        wr(4'h9, 16'h000f);
        check("irq_off", {15'h0000, irq}, 16'h0000);
        rd(4'h9, 16'h0000, "irq_stat_clr");
        wr(4'h8, 16'h0003);
        repeat (2) @(posedge sys_clk);
        rd(4'h1, 16'h780d, "an_off");
        complete_run();
    end
endmodule : psr_top_tb_top
